// >>> asac_pkg.sv
// Constants and types shared by the audio sync and gain control block
package asac_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_ROUTE = 8'h41;
  localparam logic [7:0] OFS_FILTER = 8'h42;
  localparam logic [7:0] OFS_GAIN = 8'h43;
  localparam logic [7:0] OFS_CEIL = 8'h44;
  localparam logic [7:0] OFS_AGC_CFG = 8'h45;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h10;
  localparam logic [7:0] RST_CEIL = 8'h1f;
  localparam logic [7:0] RST_AGC_CFG = 8'h3d;
  localparam logic [7:0] MASK_CTRL = 8'hff;
  localparam logic [7:0] MASK_ROUTE = 8'h07;
  localparam logic [7:0] MASK_FILTER = 8'h33;
  localparam logic [7:0] MASK_GAIN = 8'h1f;
  localparam logic [7:0] MASK_CEIL = 8'h1f;
  localparam logic [7:0] MASK_AGC_CFG = 8'h7f;
  localparam int BIT_SYNC_EN = 0;
  localparam int BIT_AGC_EN = 1;
  localparam int BIT_TRACKING_DISABLE = 2;
  localparam int POS_MODE = 3;
  localparam int BIT_PRECHARGE = 6;
  localparam int BIT_BYPASS = 7;
  localparam int POS_ATTACK = 0;
  localparam int POS_DECAY = 4;
  localparam int POS_AVE = 0;
  localparam int POS_UP = 2;
  localparam int POS_DOWN = 4;
  localparam int BIT_LOCK = 6;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DOWN_UNIT_MS = 130;
  localparam int unsigned UP_UNIT_MS = 260;
  localparam int unsigned ATTACK_BASE_US = 32;
  localparam int unsigned DOWN_UNIT_CYC = DOWN_UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned UP_UNIT_CYC = UP_UNIT_MS * (CLK_HZ / 1000);
  localparam logic [11:0] ATTACK_BASE_CYC = 12'(ATTACK_BASE_US * (CLK_HZ / 1_000_000));

  typedef enum logic [2:0] {
    ASAC_MODE_SINGLE = 3'b000,
    ASAC_MODE_PERIODIC = 3'b001,
    ASAC_MODE_ZERO_CROSS = 3'b010,
    ASAC_MODE_PERIODIC_OR_ZC = 3'b011,
    ASAC_MODE_BAR = 3'b100,
    ASAC_MODE_RGB = 3'b101
  } asac_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asac_reg_req_t;
endpackage

// >>> asac_step_timer.sv
// Gain step interval timer: one tick per (mult + 1) units while running
`timescale 1ns/10ps
module asac_step_timer #(
  parameter int unsigned UNIT_CYCLES = 1
) (
  input logic ref_clk,
  input logic rstn,
  input logic run,
  input logic [1:0] mult,
  output logic tick
);
  logic [23:0] cyc_q;
  logic [1:0] unit_q;
  wire unit_end = (cyc_q == 24'(UNIT_CYCLES - 1));
  wire step_end = unit_end && (unit_q == mult);

  assign tick = run && step_end;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_q <= 24'h00_0000;
      unit_q <= 2'h0;
    end else if (!run || step_end) begin
      cyc_q <= 24'h00_0000;
      unit_q <= 2'h0;
    end else if (unit_end) begin
      cyc_q <= 24'h00_0000;
      unit_q <= unit_q + 2'h1;
    end else begin
      cyc_q <= cyc_q + 24'h00_0001;
    end
  end
endmodule // asac_step_timer

// >>> asac_audio_sync_agc.sv
// Audio sync control registers, LED routing and preamplifier gain control
// Functional notes
// - Precharge bit drives input capacitor charge enable
// - Three-bit field selects audio LED effect
// - Tracking disable bit freezes automatic gain
// - AGC off: gain follows programmed gain field
// - AGC on: programmed gain, limited to the ceiling, is starting value
// - Sync module enabled only while enable set
// - Per-LED bits pass or block sync signal
// - Attack code picks 32/64/128/256 us
// - Automatic gain never steps above programmed ceiling; a gain above it is cut to the ceiling one cycle later
// - Down step interval 0.13 to 0.52 s
// - Up step interval 0.26 to 1.04 s
// - Registers take documented values after reset
`timescale 1ns/10ps
module asac_audio_sync_agc
  import asac_pkg::*;
#(
  parameter int unsigned DOWN_UNIT_CYCLES = DOWN_UNIT_CYC,
  parameter int unsigned UP_UNIT_CYCLES = UP_UNIT_CYC
) (
  input logic ref_clk,
  input logic rstn,
  input asac_reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input logic audio_sync_in,
  input logic level_above_attack,
  input logic level_below_release,
  output logic sync_module_enable_q,
  output logic input_cap_charge_enable_q,
  output asac_mode_t effect_mode_select_q,
  output logic [2:0] led_sync_q,
  output logic [4:0] preamp_gain_q,
  output logic gain_tracking_active_q,
  output logic [11:0] attack_cycles_q,
  output logic [1:0] peak_filter_decay_q,
  output logic [1:0] level_sampling_cycle_q
);
  logic [7:0] ctrl_q;
  logic [7:0] route_q;
  logic [7:0] filter_q;
  logic [7:0] gain_set_q;
  logic [7:0] ceil_q;
  logic [7:0] agc_cfg_q;
  logic agc_en_prev_q;
  logic gain_wr_q;
  logic [4:0] gain_d;
  logic up_tick;
  logic down_tick;

  // Register decode
  wire sel_ctrl = reg_req.wr && (reg_req.addr == OFS_CTRL);
  wire sel_route = reg_req.wr && (reg_req.addr == OFS_ROUTE);
  wire sel_filter = reg_req.wr && (reg_req.addr == OFS_FILTER);
  wire sel_gain = reg_req.wr && (reg_req.addr == OFS_GAIN);
  wire sel_ceil = reg_req.wr && (reg_req.addr == OFS_CEIL);
  wire sel_agc_cfg = reg_req.wr && (reg_req.addr == OFS_AGC_CFG);
  wire [7:0] rd_data =
    (reg_req.addr == OFS_CTRL) ? ctrl_q :
    (reg_req.addr == OFS_ROUTE) ? route_q :
    (reg_req.addr == OFS_FILTER) ? filter_q :
    (reg_req.addr == OFS_GAIN) ? gain_set_q :
    (reg_req.addr == OFS_CEIL) ? ceil_q :
    (reg_req.addr == OFS_AGC_CFG) ? agc_cfg_q : 8'h00;

  // Gain control terms
  wire agc_en = ctrl_q[BIT_AGC_EN];
  wire tracking = agc_en && !ctrl_q[BIT_TRACKING_DISABLE];
  wire [4:0] gain_set = gain_set_q[4:0];
  wire [4:0] ceil = ceil_q[4:0];
  wire [4:0] load_value = (gain_set > ceil) ? ceil : gain_set;
  wire reload = agc_en && (!agc_en_prev_q || gain_wr_q);
  wire up_run = tracking && !reload && level_below_release && !level_above_attack && (preamp_gain_q < ceil);
  wire down_run = tracking && !reload && level_above_attack && (preamp_gain_q != 5'h00);
  wire [1:0] up_mult = agc_cfg_q[POS_UP +: 2];
  wire [1:0] down_mult = agc_cfg_q[POS_DOWN +: 2];
  wire [2:0] route_bits = route_q[2:0] & {3{ctrl_q[BIT_SYNC_EN] & audio_sync_in}};
  wire [11:0] attack_d = ATTACK_BASE_CYC << filter_q[POS_ATTACK +: 2];

  asac_step_timer #(.UNIT_CYCLES(UP_UNIT_CYCLES)) u_up_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(up_run),
    .mult(up_mult),
    .tick(up_tick)
  );

  asac_step_timer #(.UNIT_CYCLES(DOWN_UNIT_CYCLES)) u_down_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(down_run),
    .mult(down_mult),
    .tick(down_tick)
  );

  always_comb begin
    gain_d = preamp_gain_q;
    if (!agc_en) begin
      gain_d = gain_set;
    end else if (reload) begin
      gain_d = load_value;
    end else if (preamp_gain_q > ceil) begin
      gain_d = ceil;
    end else if (down_tick) begin
      gain_d = preamp_gain_q - 5'h01;
    end else if (up_tick) begin
      gain_d = preamp_gain_q + 5'h01;
    end
  end

  // Register file, reserved bits masked to zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= RST_CTRL;
      route_q <= RST_ROUTE;
      filter_q <= RST_FILTER;
      gain_set_q <= RST_GAIN;
      ceil_q <= RST_CEIL;
      agc_cfg_q <= RST_AGC_CFG;
    end else begin
      if (sel_ctrl) ctrl_q <= reg_req.wdata & MASK_CTRL;
      if (sel_route) route_q <= reg_req.wdata & MASK_ROUTE;
      if (sel_filter) filter_q <= reg_req.wdata & MASK_FILTER;
      if (sel_gain) gain_set_q <= reg_req.wdata & MASK_GAIN;
      if (sel_ceil) ceil_q <= reg_req.wdata & MASK_CEIL;
      if (sel_agc_cfg) agc_cfg_q <= reg_req.wdata & MASK_AGC_CFG;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q <= reg_req.rd ? rd_data : 8'h00;
      reg_rvalid_q <= reg_req.rd;
    end
  end

  // Outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_module_enable_q <= 1'b0;
      input_cap_charge_enable_q <= 1'b0;
      effect_mode_select_q <= ASAC_MODE_SINGLE;
      led_sync_q <= 3'h0;
      attack_cycles_q <= ATTACK_BASE_CYC;
      peak_filter_decay_q <= 2'h0;
      level_sampling_cycle_q <= RST_AGC_CFG[POS_AVE +: 2];
      gain_tracking_active_q <= 1'b0;
    end else begin
      sync_module_enable_q <= ctrl_q[BIT_SYNC_EN];
      input_cap_charge_enable_q <= ctrl_q[BIT_PRECHARGE];
      effect_mode_select_q <= asac_mode_t'(ctrl_q[POS_MODE +: 3]);
      led_sync_q <= route_bits;
      attack_cycles_q <= attack_d;
      peak_filter_decay_q <= filter_q[POS_DECAY +: 2];
      level_sampling_cycle_q <= agc_cfg_q[POS_AVE +: 2];
      gain_tracking_active_q <= tracking;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      preamp_gain_q <= RST_GAIN[4:0];
      agc_en_prev_q <= 1'b0;
      gain_wr_q <= 1'b0;
    end else begin
      preamp_gain_q <= gain_d;
      agc_en_prev_q <= agc_en;
      gain_wr_q <= sel_gain;
    end
  end

  // Checks
  precharge_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sel_ctrl |-> ##2 input_cap_charge_enable_q == $past(reg_req.wdata[BIT_PRECHARGE], 2))
    else $error("precharge enable does not follow control write");
  mode_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sel_ctrl |-> ##2 effect_mode_select_q == $past(reg_req.wdata[5:3], 2))
    else $error("effect mode does not follow control write");
  track_freeze_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (agc_en && ctrl_q[BIT_TRACKING_DISABLE] && !reload && !reg_req.wr && preamp_gain_q <= ceil) |=> $stable(preamp_gain_q))
    else $error("gain moved while tracking disabled");
  fixed_gain_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !agc_en |=> preamp_gain_q == $past(gain_set))
    else $error("fixed gain differs from programmed gain");
  agc_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (agc_en && !agc_en_prev_q) |=> preamp_gain_q == $past(load_value))
    else $error("automatic gain did not start from programmed gain");
  sync_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sel_ctrl |-> ##2 sync_module_enable_q == $past(reg_req.wdata[BIT_SYNC_EN], 2))
    else $error("sync enable does not follow control write");
  decay_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sel_filter |-> ##2 peak_filter_decay_q == $past(reg_req.wdata[5:4], 2))
    else $error("decay field does not follow filter write");
  sync_enable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !sync_module_enable_q |-> led_sync_q == 3'h0 || $past(ctrl_q[BIT_SYNC_EN]))
    else $error("sync output active while module disabled");
  route_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ##1 led_sync_q == ($past(route_q[2:0]) & {3{$past(ctrl_q[0] & audio_sync_in)}}))
    else $error("LED routing mismatch");
  attack_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sel_filter |-> ##2 attack_cycles_q == (ATTACK_BASE_CYC << $past(reg_req.wdata[1:0], 2)))
    else $error("attack time mismatch");
  gain_ceiling_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (agc_en && $past(agc_en) && !$past(reg_req.wr) && !$past(gain_wr_q)) |-> preamp_gain_q <= ceil)
    else $error("gain above ceiling");
  reset_value_a: assert property (@(posedge ref_clk)
    $rose(rstn) |-> (agc_cfg_q == RST_AGC_CFG && gain_set_q == RST_GAIN && ctrl_q == RST_CTRL))
    else $error("wrong value after reset");
  single_step_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tracking && !reload && preamp_gain_q <= ceil) |=>
      (preamp_gain_q == $past(preamp_gain_q) || preamp_gain_q == $past(preamp_gain_q) + 5'h01 ||
       preamp_gain_q == $past(preamp_gain_q) - 5'h01))
    else $error("gain moved by more than one step");

  up_step_c: cover property (@(posedge ref_clk) disable iff (!rstn) up_tick);
  down_step_c: cover property (@(posedge ref_clk) disable iff (!rstn) down_tick);
  agc_reload_c: cover property (@(posedge ref_clk) disable iff (!rstn) reload);
  led_route_c: cover property (@(posedge ref_clk) disable iff (!rstn) led_sync_q == 3'h7);
  track_off_c: cover property (@(posedge ref_clk) disable iff (!rstn) agc_en && !gain_tracking_active_q);
endmodule // asac_audio_sync_agc

// >>> tb_asac.sv
// Self-checking testbench for the audio sync and gain control block
`timescale 1ns/10ps
module tb;
  import asac_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  asac_reg_req_t rq = '0;
  logic sync_in = 1'b0;
  logic lvl_hi = 1'b0;
  logic lvl_lo = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic sync_en;
  logic cap_en;
  asac_mode_t mode;
  logic [2:0] led;
  logic [4:0] gain;
  logic trk;
  logic [11:0] attack;
  logic [1:0] decay;
  logic [1:0] ave;
  logic [7:0] v;
  logic [4:0] g_a;
  logic [4:0] g_b;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] ra [7] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h50};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h1f, 8'h3d, 8'h00};

  asac_audio_sync_agc #(.DOWN_UNIT_CYCLES(4), .UP_UNIT_CYCLES(8)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .reg_req(rq), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .audio_sync_in(sync_in), .level_above_attack(lvl_hi), .level_below_release(lvl_lo),
    .sync_module_enable_q(sync_en), .input_cap_charge_enable_q(cap_en), .effect_mode_select_q(mode),
    .led_sync_q(led), .preamp_gain_q(gain), .gain_tracking_active_q(trk), .attack_cycles_q(attack),
    .peak_filter_decay_q(decay), .level_sampling_cycle_q(ave)
  );

  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Write strobe for one cycle, then one idle cycle so derived outputs settle
  task wr(input logic [7:0] a, input logic [7:0] d);
    rq.addr = a;
    rq.wdata = d;
    rq.wr = 1'b1;
    tick(1);
    rq.wr = 1'b0;
    tick(1);
  endtask

  // Read data only counts when the valid pulse is present
  task rd(input logic [7:0] a, output logic [7:0] d);
    rq.addr = a;
    rq.rd = 1'b1;
    tick(1);
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
    rq.rd = 1'b0;
    tick(1);
  endtask

  // Hold one level request, sample gain twice, then release it
  task hold(input logic up, input int pre, input int post, output logic [4:0] a, output logic [4:0] b);
    lvl_lo = up;
    lvl_hi = ~up;
    tick(pre);
    a = gain;
    tick(post);
    b = gain;
    lvl_lo = 1'b0;
    lvl_hi = 1'b0;
    tick(1);
  endtask

  initial begin
    tick(6);
    rstn = 1'b1;
    tick(1);
    chk(12'(gain), 12'h0010);
    chk(attack, 12'h0140);
    chk(12'(ave), 12'h0001);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], v);
      chk(12'(v), 12'(rv[i]));
    end
    $display("test reset values done");
    sync_in = 1'b1;
    for (int m = 0; m < 6; m++) begin
      wr(OFS_CTRL, 8'(m * 8 + 1) | ((m % 2) ? 8'h40 : 8'h00));
      chk(12'(mode), 12'(m));
      chk(12'(cap_en), 12'(m % 2));
      chk(12'(sync_en), 12'h0001);
    end
    $display("test modes done");
    for (int r = 0; r < 8; r++) begin
      wr(OFS_ROUTE, 8'(r));
      chk(12'(led), 12'(r));
    end
    sync_in = 1'b0;
    tick(2);
    chk(12'(led), 12'h0000);
    sync_in = 1'b1;
    wr(OFS_CTRL, 8'h00);
    chk(12'(sync_en), 12'h0000);
    chk(12'(led), 12'h0000);
    $display("test routing done");
    for (int a = 0; a < 4; a++) begin
      wr(OFS_FILTER, 8'(a) | 8'h20);
      chk(attack, 12'h0140 << a);
      chk(12'(decay), 12'h0002);
    end
    wr(OFS_FILTER, 8'hff);
    rd(OFS_FILTER, v);
    chk(12'(v), 12'h0033);
    $display("test filter done");
    wr(OFS_GAIN, 8'h0a);
    chk(12'(gain), 12'h000a);
    wr(OFS_CEIL, 8'h08);
    wr(OFS_AGC_CFG, 8'h01);
    wr(OFS_CTRL, 8'h02);
    chk(12'(gain), 12'h0008);
    chk(12'(trk), 12'h0001);
    hold(1'b0, 2, 4, g_a, g_b);
    chk(12'(g_a), 12'h0008);
    chk(12'(g_b), 12'h0007);
    hold(1'b1, 6, 4, g_a, g_b);
    chk(12'(g_a), 12'h0007);
    chk(12'(g_b), 12'h0008);
    hold(1'b1, 20, 1, g_a, g_b);
    chk(12'(g_b), 12'h0008);
    wr(OFS_AGC_CFG, 8'h31);
    hold(1'b0, 14, 4, g_a, g_b);
    chk(12'(g_a), 12'h0008);
    chk(12'(g_b), 12'h0007);
    wr(OFS_AGC_CFG, 8'h0d);
    hold(1'b1, 30, 4, g_a, g_b);
    chk(12'(g_a), 12'h0007);
    chk(12'(g_b), 12'h0008);
    wr(OFS_CTRL, 8'h06);
    chk(12'(trk), 12'h0000);
    hold(1'b0, 20, 1, g_a, g_b);
    chk(12'(g_b), 12'h0008);
    wr(OFS_CTRL, 8'h02);
    wr(OFS_CEIL, 8'h05);
    tick(1);
    chk(12'(gain), 12'h0005);
    wr(OFS_CTRL, 8'h00);
    chk(12'(gain), 12'h000a);
    $display("test gain control done");
    summarize();
  end
endmodule // tb
